// ---- csl_pkg.sv ----
package csl_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_STATUS = 8'h13;
  localparam logic [7:0] IDX_CURRENT = 8'h14;
  localparam logic [7:0] IDX_VOLTAGE = 8'h15;
  localparam logic [7:0] IDX_SETPT = 8'h16;
  localparam logic [6:0] SLAVE_ADDR = 7'h12;
  // Reset values of the host words
  localparam logic [15:0] CURRENT_RST = 16'h0000;
  localparam logic [15:0] VOLTAGE_RST = 16'h0000;
  // Voltage word decoding
  localparam int V_LSB_POS = 4;
  localparam int V_BITS = 11;
  localparam logic [15:0] V_OVR_WORD = 16'h4800;
  localparam logic [15:0] V_MIN_WORD = 16'h0400;
  localparam logic [10:0] V_FULL_CODE = 11'h480;
  // Current word decoding
  localparam int I_LSB_POS = 6;
  localparam int I_BITS = 6;
  localparam logic [15:0] I_OVR_WORD = 16'h0BC0;
  localparam logic [15:0] I_MIN_WORD = 16'h0080;
  localparam logic [5:0] I_FULL_CODE = 6'h2F;
  localparam logic [5:0] I_TRICKLE_CODE = 6'h02;
  // Status bit positions
  localparam int ST_INPUT = 15;
  localparam int ST_BATTERY_PIN = 14;
  localparam int ST_PFAIL = 13;
  localparam int ST_CHG = 0;
  localparam int ST_TRICKLE = 1;
  localparam int ST_TIMEOUT = 2;
  localparam int ST_SUPPLY_UV = 3;
  // Comparator vector positions
  localparam int CMP_INPUT = 0;
  localparam int CMP_PFAIL = 1;
  localparam int CMP_BATTERY_PIN = 2;
  localparam int CMP_BLOW = 3;
  localparam int CMP_BREC = 4;
  localparam int CMP_SUV = 5;
  localparam int CMP_N = 6;
  // Safety timeout
  localparam longint WDT_S = 175;
  localparam longint CLK_HZ = 125_000_000;
  localparam longint WDT_CYC = WDT_S * CLK_HZ;
  // Set point bundle sent to the converter side
  typedef struct packed {
    logic en;
    logic [10:0] v;
    logic [5:0] i;
  } csl_sp_t;
  // Register bus request
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] idx;
    logic [15:0] wdata;
  } csl_req_t;
endpackage : csl_pkg

// ---- csl_core.sv ----
`timescale 1ns/10ps
// Operation
// R1: Voltage code is word bits 14:4
// R2: Voltage at or above boundary clamps full-scale
// R3: Voltage below minimum stops charging
// R4: Current code is word bits 11:6
// R5: Current above boundary clamps full-scale
// R6: Current below minimum switches current off
// R7: Input present allows charging, status bit 15
// R8: Power fail opens source switch, bit 13
// R9: Battery present sets bit 14, permits charging
// R10: No battery holds host registers reset
// R11: No battery: full-scale voltage, trickle current
// R12: Battery undervoltage forces trickle, words kept
// R13: Supply undervoltage ignores bus, resets, stops
// R14: Slave answers at one fixed address; SLAVE_ADDR is never decoded, every Avalon request is answered
// R15: Current and voltage written as words
// R16: Status word read by its command
// R17: Stop charging without fresh word before timeout
// R18: Comparator results synchronized before use
module csl_core #(
  parameter longint WDT_CYCLES = csl_pkg::WDT_CYC
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic link_clk_i,
  // Avalon-MM slave
  input wire logic [9:0] address_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic [31:0] writedata_i,
  input wire logic [3:0] byteenable_i,
  output logic [31:0] readdata_o,
  output logic waitrequest_o,
  // Comparator results, asynchronous
  input wire logic input_present_i,
  input wire logic power_fail_i,
  input wire logic battery_present_i,
  input wire logic battery_low_i,
  input wire logic battery_recover_i,
  input wire logic supply_uv_i,
  // Source switch
  output logic source_switch_drive_o,
  // Converter side, link clock
  output logic charge_en_o,
  output logic [10:0] dac_v_code_o,
  output logic [5:0] dac_i_code_o
);

  // Two-stage synchronizer for all comparators
  logic [csl_pkg::CMP_N-1:0] cmp_raw;
  logic [csl_pkg::CMP_N-1:0] cmp_s1_r;
  logic [csl_pkg::CMP_N-1:0] cmp_r;
  assign cmp_raw = {supply_uv_i, battery_recover_i, battery_low_i,
                    battery_present_i, power_fail_i, input_present_i};

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cmp_s1_r <= '0;
      cmp_r <= '0;
    end else begin
      cmp_s1_r <= cmp_raw; // R18
      cmp_r <= cmp_s1_r;
    end
  end

  wire input_ok = cmp_r[csl_pkg::CMP_INPUT];
  wire pfail = cmp_r[csl_pkg::CMP_PFAIL];
  wire battery_pin_ok = cmp_r[csl_pkg::CMP_BATTERY_PIN];
  wire supply_uv = cmp_r[csl_pkg::CMP_SUV];

  // Bus request decode
  csl_pkg::csl_req_t req;
  assign req.rd = read_i;
  assign req.wr = write_i;
  assign req.idx = address_i[9:2];
  assign req.wdata = writedata_i[15:0];

  logic wait_r;
  logic [31:0] rdata_r;
  wire req_any = req.rd | req.wr;
  wire accept = req_any & ~wait_r;
  // Low lanes must be enabled, otherwise the write is dropped
  wire lanes_ok = &byteenable_i[1:0];
  // Supply undervoltage and battery removal both force the reset state
  wire hold_rst = supply_uv | ~battery_pin_ok; // R10 R13
  wire wr_ok = accept & req.wr & lanes_ok & ~supply_uv; // R13
  wire wr_cur = wr_ok & (req.idx == csl_pkg::IDX_CURRENT); // R15
  wire wr_vol = wr_ok & (req.idx == csl_pkg::IDX_VOLTAGE); // R15

  // Host words and safety timer
  logic [15:0] cur_r;
  logic [15:0] vol_r;
  logic [35:0] wdt_r;
  logic tout_r;
  logic uvb_r;
  localparam logic [35:0] WDT_LAST = 36'(WDT_CYCLES - 1);
  wire wdt_end = (wdt_r == WDT_LAST);

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cur_r <= csl_pkg::CURRENT_RST;
      vol_r <= csl_pkg::VOLTAGE_RST;
    end else if (hold_rst) begin
      cur_r <= csl_pkg::CURRENT_RST; // R10
      vol_r <= csl_pkg::VOLTAGE_RST;
    end else begin
      if (wr_cur) cur_r <= req.wdata;
      if (wr_vol) vol_r <= req.wdata;
    end
  end

  // Timer restarts on every accepted set-point word; timeout is sticky
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wdt_r <= '0;
      tout_r <= 1'b0;
    end else if (hold_rst || wr_cur || wr_vol) begin
      wdt_r <= '0;
      tout_r <= 1'b0;
    end else if (!tout_r) begin
      wdt_r <= wdt_r + 36'h1;
      tout_r <= wdt_end; // R17
    end
  end

  // Battery undervoltage with hysteresis: set below low, clear above recover
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) uvb_r <= 1'b0;
    else if (cmp_r[csl_pkg::CMP_BLOW]) uvb_r <= 1'b1; // R12
    else if (cmp_r[csl_pkg::CMP_BREC]) uvb_r <= 1'b0;
  end

  // Set-point decoding
  wire [10:0] v_raw = vol_r[csl_pkg::V_LSB_POS +: csl_pkg::V_BITS]; // R1
  wire v_ovr = vol_r >= csl_pkg::V_OVR_WORD;
  wire v_low = vol_r < csl_pkg::V_MIN_WORD;
  wire [10:0] v_code = v_ovr ? csl_pkg::V_FULL_CODE : v_raw; // R2
  wire [5:0] i_raw = cur_r[csl_pkg::I_LSB_POS +: csl_pkg::I_BITS]; // R4
  wire i_ovr = cur_r > csl_pkg::I_OVR_WORD;
  wire i_low = cur_r < csl_pkg::I_MIN_WORD;
  wire [5:0] i_norm = i_ovr ? csl_pkg::I_FULL_CODE : (i_low ? 6'h00 : i_raw); // R5 R6
  // Trickle only ever lowers the current, never raises it
  wire [5:0] i_code = (uvb_r && i_norm > csl_pkg::I_TRICKLE_CODE) ?
                      csl_pkg::I_TRICKLE_CODE : i_norm; // R12
  wire can_chg = input_ok & ~pfail & ~supply_uv; // R7 R13
  wire run_chg = can_chg & battery_pin_ok & ~v_low & ~i_low & ~tout_r; // R3 R6 R9 R17

  csl_pkg::csl_sp_t sp_nxt;
  assign sp_nxt.en = battery_pin_ok ? run_chg : can_chg; // R11
  assign sp_nxt.v = battery_pin_ok ? v_code : csl_pkg::V_FULL_CODE; // R11
  assign sp_nxt.i = battery_pin_ok ? i_code : csl_pkg::I_TRICKLE_CODE; // R11

  // Status word
  logic [15:0] status;
  always_comb begin
    status = 16'h0000;
    status[csl_pkg::ST_INPUT] = input_ok; // R7
    status[csl_pkg::ST_BATTERY_PIN] = battery_pin_ok; // R9
    status[csl_pkg::ST_PFAIL] = pfail; // R8
    status[csl_pkg::ST_CHG] = sp_nxt.en;
    status[csl_pkg::ST_TRICKLE] = uvb_r;
    status[csl_pkg::ST_TIMEOUT] = tout_r;
    status[csl_pkg::ST_SUPPLY_UV] = supply_uv;
  end

  // Read mux; unmapped and undervoltage reads return zero
  wire [15:0] rd_mux =
    supply_uv ? 16'h0000 :
    (req.idx == csl_pkg::IDX_STATUS) ? status : // R16
    (req.idx == csl_pkg::IDX_CURRENT) ? cur_r :
    (req.idx == csl_pkg::IDX_VOLTAGE) ? vol_r :
    (req.idx == csl_pkg::IDX_SETPT) ? {sp_nxt.en, 4'h0, sp_nxt.v} :
    16'h0000; // R14

  // One wait cycle per request, answer on the following edge
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wait_r <= 1'b1;
      rdata_r <= 32'h0000_0000;
    end else begin
      wait_r <= ~(req_any & wait_r);
      if (req.rd && wait_r) rdata_r <= {16'h0000, rd_mux};
    end
  end
  assign waitrequest_o = wait_r;
  assign readdata_o = rdata_r;

  // Source switch opens during power fail
  logic src_r;
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) src_r <= 1'b0;
    else src_r <= input_ok & ~pfail & ~supply_uv; // R8
  end
  assign source_switch_drive_o = src_r;

  // Toggle handshake to the link domain; bundle held stable while pending
  csl_pkg::csl_sp_t snap_r;
  logic req_t_r;
  logic ack_s1_r;
  logic ack_s2_r;
  logic ack_t_r;
  logic lreq_s1_r;
  logic lreq_s2_r;
  wire idle = (req_t_r == ack_s2_r);

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      snap_r <= '0;
      req_t_r <= 1'b0;
      ack_s1_r <= 1'b0;
      ack_s2_r <= 1'b0;
    end else begin
      ack_s1_r <= ack_t_r;
      ack_s2_r <= ack_s1_r;
      if (idle && (sp_nxt != snap_r || req_t_r != ack_s2_r)) begin
        snap_r <= sp_nxt;
        req_t_r <= ~req_t_r;
      end
    end
  end

  // Link-domain capture of the set points
  csl_pkg::csl_sp_t out_r;
  always_ff @(posedge link_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      lreq_s1_r <= 1'b0;
      lreq_s2_r <= 1'b0;
      ack_t_r <= 1'b0;
      out_r <= '0;
    end else begin
      lreq_s1_r <= req_t_r;
      lreq_s2_r <= lreq_s1_r;
      if (lreq_s2_r != ack_t_r) begin
        out_r <= snap_r;
        ack_t_r <= lreq_s2_r;
      end
    end
  end
  assign charge_en_o = out_r.en;
  assign dac_v_code_o = out_r.v;
  assign dac_i_code_o = out_r.i;

  // Checks on the system clock
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!resetn_i);

  v_code_a: assert property (battery_pin_ok && !v_ovr |-> sp_nxt.v == vol_r[14:4]) // R1
    else $error("voltage code not taken from word");
  v_clamp_a: assert property (battery_pin_ok && vol_r >= 16'h4800 |-> sp_nxt.v == 11'h480) // R2
    else $error("voltage overrange not clamped");
  v_min_a: assert property (battery_pin_ok && vol_r < 16'h0400 |-> !sp_nxt.en) // R3
    else $error("charging with voltage below minimum");
  i_code_a: assert property (battery_pin_ok && !uvb_r && cur_r >= 16'h0080 && cur_r <= 16'h0BC0
    |-> sp_nxt.i == cur_r[11:6]) // R4
    else $error("current code not taken from word");
  i_clamp_a: assert property (battery_pin_ok && !uvb_r && cur_r > 16'h0BC0 |-> sp_nxt.i == 6'h2F) // R5
    else $error("current overrange not clamped");
  i_off_a: assert property (battery_pin_ok && cur_r < 16'h0080 |-> sp_nxt.i == 6'h00 && !sp_nxt.en) // R6
    else $error("current not off below minimum");
  in_bit_a: assert property (input_ok |-> status[15]) // R7
    else $error("input present bit missing");
  pfail_a: assert property ($rose(pfail) |=> !source_switch_drive_o && status[13]) // R8
    else $error("power fail did not open source switch");
  bat_bit_a: assert property (status[14] == battery_pin_ok) // R9
    else $error("battery bit wrong");
  nobat_reg_a: assert property (!battery_pin_ok |=> cur_r == 16'h0000 && vol_r == 16'h0000) // R10
    else $error("registers not held without battery");
  nobat_sp_a: assert property (!battery_pin_ok |-> sp_nxt.v == 11'h480 && sp_nxt.i == 6'h02) // R11
    else $error("no-battery set point wrong");
  trickle_a: assert property (uvb_r && battery_pin_ok |-> sp_nxt.i <= 6'h02 && ($stable(cur_r) || $past(wr_cur) || $past(hold_rst))) // R12
    else $error("undervoltage current not limited");
  uv_ign_a: assert property (supply_uv |-> !sp_nxt.en ##1 (cur_r == 16'h0000)) // R13
    else $error("supply undervoltage not handled");
  bus_ans_a: assert property (req_any && wait_r |=> !waitrequest_o ##1 waitrequest_o) // R15
    else $error("bus answer timing wrong");
  // Skip the first two edges after reset, the pipe still holds reset zeros then
  sync_a: assert property ($past(resetn_i, 2) |-> cmp_r == $past(cmp_raw, 2)) // R18
    else $error("comparator sync depth wrong");
  tout_a: assert property (tout_r |-> !sp_nxt.en) // R17
    else $error("charging after safety timeout");

  // Source switch and charge enable against the comparator levels
  // Switch closes one edge after conditions become good
  src_on_a: assert property (input_ok && !pfail && !supply_uv |=> source_switch_drive_o) // R8
    else $error("source switch not closed");

  // Supply undervoltage always opens the switch
  src_uv_a: assert property (supply_uv |=> !source_switch_drive_o) // R13
    else $error("source switch closed in undervoltage");

  // Power fail bit follows the synchronized comparator
  pf_bit_a: assert property (status[13] == pfail) // R8
    else $error("power fail bit wrong");

  // No input, no charging, battery or not
  chg_in_a: assert property (!input_ok |-> !sp_nxt.en) // R7
    else $error("charging without input");

  // Power fail blocks charging
  pf_en_a: assert property (pfail |-> !sp_nxt.en) // R8
    else $error("charging in power fail");

  // Without battery the enable depends on the supply side only
  nobat_en_a: assert property (!battery_pin_ok |-> sp_nxt.en == (input_ok && !pfail && !supply_uv)) // R11
    else $error("no-battery enable wrong");

  // Legal words with good supply give charging
  chg_ok_a: assert property (battery_pin_ok && vol_r >= 16'h0400 && cur_r >= 16'h0080 && input_ok && !pfail
    && !supply_uv && !tout_r |-> sp_nxt.en) // R3
    else $error("charging not enabled for legal words");

  // Battery removal clears the timeout too
  nobat_tout_a: assert property (!battery_pin_ok |=> !tout_r) // R17
    else $error("timeout kept without battery");

  // Supply undervoltage returns the words to reset
  uv_rst_a: assert property (supply_uv |=> cur_r == 16'h0000 && vol_r == 16'h0000) // R13
    else $error("words not reset in undervoltage");

  // Reads during undervoltage return zero
  uv_rd_a: assert property (supply_uv && req.rd && wait_r |=> readdata_o == 32'h0000_0000) // R13
    else $error("read answered in undervoltage");

  // Undervoltage status bit follows the comparator
  uv_st_a: assert property (status[3] == supply_uv) // R13
    else $error("supply undervoltage bit wrong");

  // Register bus checks
  // An accepted current write lands at the next edge
  cur_land_a: assert property (wr_cur && !hold_rst |=> cur_r == $past(writedata_i[15:0])) // R15
    else $error("current write lost");

  // An accepted voltage write lands at the next edge
  vol_land_a: assert property (wr_vol && !hold_rst |=> vol_r == $past(writedata_i[15:0])) // R15
    else $error("voltage write lost");

  // Partial low lanes never change a word
  part_lane_a: assert property (!hold_rst && accept && req.wr && !lanes_ok |=> $stable(cur_r) && $stable(vol_r)) // R15
    else $error("partial write changed a word");

  // No request keeps waitrequest high
  wait_idle_a: assert property (!req_any |=> waitrequest_o) // R15
    else $error("waitrequest low without request");

  // Waitrequest is low for one cycle only
  wait_one_a: assert property (!waitrequest_o |=> waitrequest_o) // R15
    else $error("waitrequest low too long");

  // Upper read half is always zero
  rd_hi_a: assert property (readdata_o[31:16] == 16'h0000) // R16
    else $error("upper read data not zero");

  // Status read returns the status word of the accepting edge
  st_rd_a: assert property (req.rd && wait_r && !supply_uv && req.idx == csl_pkg::IDX_STATUS
    |=> readdata_o[15:0] == $past(status)) // R16
    else $error("status read data wrong");

  // Safety timer and trickle state
  // Timer end sets the sticky timeout unless a write or the reset hold restarts it
  tout_set_a: assert property (wdt_end && !tout_r && !hold_rst && !wr_cur && !wr_vol |=> tout_r) // R17
    else $error("timeout not set at timer end");

  // A fresh word clears the timeout
  tout_clr_a: assert property (wr_cur || wr_vol |=> !tout_r) // R17
    else $error("timeout not cleared by write");

  // Low comparator sets trickle
  uvb_set_a: assert property (cmp_r[csl_pkg::CMP_BLOW] |=> uvb_r) // R12
    else $error("trickle not entered");

  // Recover comparator clears trickle when low is gone
  uvb_clr_a: assert property (!cmp_r[csl_pkg::CMP_BLOW] && cmp_r[csl_pkg::CMP_BREC] |=> !uvb_r) // R12
    else $error("trickle not left");

  // Trickle bit follows the trickle state
  trk_bit_a: assert property (status[1] == uvb_r) // R12
    else $error("trickle bit wrong");

endmodule : csl_core

// ---- csl_conv_model.sv ----
`timescale 1ns/10ps
module csl_conv_model (
  // Link side
  input wire logic link_clk_i,
  input wire logic resetn_i,
  // Set points from the block
  input wire logic charge_en_i,
  input wire logic [10:0] dac_v_code_i,
  input wire logic [5:0] dac_i_code_i,
  // Set point as the converter holds it
  output csl_pkg::csl_sp_t sp_o
);
  // Taken on the link clock only, so a badly crossed bundle shows up here
  always_ff @(posedge link_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sp_o <= '0;
    end else begin
      sp_o <= '{en: charge_en_i, v: dac_v_code_i, i: dac_i_code_i};
    end
  end
endmodule : csl_conv_model

// ---- charger_setpoint_status_logic_test.sv ----
`timescale 1ns/10ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin bad_count++; \
  $display("MISMATCH %s expected %h seen %h", n, e, g); end end
module charger_setpoint_status_logic_test;
  logic sys_clk_i = 1'b0;
  logic link_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [9:0] address_i = '0;
  logic read_i = 1'b0;
  logic write_i = 1'b0;
  logic [31:0] writedata_i = '0;
  logic [3:0] byteenable_i = 4'hF;
  logic [31:0] readdata_o;
  logic waitrequest_o;
  logic inp = 1'b1, pf = 1'b0, bat = 1'b1, blow = 1'b0, brec = 1'b0, suv = 1'b0;
  logic source_switch_drive_o, charge_en_o;
  logic [10:0] dac_v_code_o;
  logic [5:0] dac_i_code_o;
  csl_pkg::csl_sp_t sp;
  int bad_count = 0;
  int checks = 0;
  logic [15:0] q;
  // Clocks: link clock offset and slower; rising edges still coincide every 120 ns
  always #4 sys_clk_i = ~sys_clk_i;
  initial begin
    #3;
    forever #15 link_clk_i = ~link_clk_i;
  end
  // Short watchdog so the expiry is reached in a few hundred cycles
  csl_core #(.WDT_CYCLES(200)) uut (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .link_clk_i(link_clk_i),
    .address_i(address_i), .read_i(read_i), .write_i(write_i), .writedata_i(writedata_i),
    .byteenable_i(byteenable_i), .readdata_o(readdata_o), .waitrequest_o(waitrequest_o),
    .input_present_i(inp), .power_fail_i(pf), .battery_present_i(bat), .battery_low_i(blow),
    .battery_recover_i(brec), .supply_uv_i(suv), .source_switch_drive_o(source_switch_drive_o),
    .charge_en_o(charge_en_o), .dac_v_code_o(dac_v_code_o), .dac_i_code_o(dac_i_code_o));
  csl_conv_model conv (.link_clk_i(link_clk_i), .resetn_i(resetn_i), .charge_en_i(charge_en_o),
    .dac_v_code_i(dac_v_code_o), .dac_i_code_i(dac_i_code_o), .sp_o(sp));
  // Verdict
  task results;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : results
  // One Avalon access, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [7:0] idx, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge sys_clk_i);
    address_i <= {idx, 2'b00};
    writedata_i <= {16'h0000, d};
    write_i <= w;
    read_i <= ~w;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (waitrequest_o !== 1'b0 && n < 20);
    if (n >= 20) begin
      bad_count++;
      results();
    end
    q = readdata_o[15:0];
    write_i <= 1'b0;
    read_i <= 1'b0;
  endtask : bus
  // Word helpers; command indices as the host uses them
  task automatic wr(input logic [7:0] idx, input logic [15:0] d);
    bus(1'b1, idx, d);
  endtask : wr
  task automatic rd(input logic [7:0] idx);
    bus(1'b0, idx, 16'h0000);
  endtask : rd
  task automatic setw(input logic [15:0] i, input logic [15:0] v);
    wr(csl_pkg::IDX_CURRENT, i);
    wr(csl_pkg::IDX_VOLTAGE, v);
  endtask : setw
  task automatic cmpw;
    repeat (4) @(posedge sys_clk_i);
  endtask : cmpw
  // Converter sees the set point after the crossing, the register view agrees
  task automatic spc(input logic en, input logic [10:0] v, input logic [5:0] i);
    repeat (12) @(posedge link_clk_i);
    `CHK("link en", en, sp.en)
    `CHK("link i", i, sp.i)
    rd(csl_pkg::IDX_SETPT);
    `CHK("setpt en", en, q[15])
    if (en) begin
      `CHK("link v", v, sp.v)
      `CHK("setpt v", v, q[10:0])
    end
  endtask : spc
  task automatic t_reset;
    rd(csl_pkg::IDX_STATUS);
    `CHK("status flags", 3'b110, q[15:13])
    rd(csl_pkg::IDX_CURRENT);
    `CHK("current rst", csl_pkg::CURRENT_RST, q)
    rd(csl_pkg::IDX_VOLTAGE);
    `CHK("voltage rst", csl_pkg::VOLTAGE_RST, q)
    rd(8'h20);
    `CHK("unmapped", 16'h0000, q)
    `CHK("source on", 1'b1, source_switch_drive_o)
    $display("done t_reset");
  endtask : t_reset
  task automatic t_volt;
    logic [15:0] w[6] = '{16'h4800, 16'hFFFF, 16'h47FF, 16'h0400, 16'h03FF, 16'h1234};
    logic [10:0] c[6] = '{11'h480, 11'h480, 11'h47F, 11'h040, 11'h000, 11'h123};
    for (int k = 0; k < 6; k++) begin
      setw(16'h0400, w[k]);
      rd(csl_pkg::IDX_VOLTAGE);
      `CHK("voltage word", w[k], q)
      spc(k != 4, c[k], 6'h10);
    end
    $display("done t_volt");
  endtask : t_volt
  task automatic t_curr;
    logic [15:0] w[6] = '{16'h0BC0, 16'h0BC1, 16'hFFFF, 16'h0080, 16'h007F, 16'h0440};
    logic [5:0] c[6] = '{6'h2F, 6'h2F, 6'h2F, 6'h02, 6'h00, 6'h11};
    for (int k = 0; k < 6; k++) begin
      setw(w[k], 16'h3000);
      spc(k != 4, 11'h300, c[k]);
    end
    $display("done t_curr");
  endtask : t_curr
  task automatic t_stat;
    setw(16'h0400, 16'h3000);
    pf <= 1'b1;
    cmpw();
    rd(csl_pkg::IDX_STATUS);
    `CHK("pfail bit", 1'b1, q[13])
    `CHK("source off", 1'b0, source_switch_drive_o)
    pf <= 1'b0;
    inp <= 1'b0;
    cmpw();
    rd(csl_pkg::IDX_STATUS);
    `CHK("input bit", 1'b0, q[15])
    inp <= 1'b1;
    setw(16'h0400, 16'h3000);
    blow <= 1'b1;
    cmpw();
    blow <= 1'b0;
    spc(1'b1, 11'h300, 6'h02);
    rd(csl_pkg::IDX_CURRENT);
    `CHK("current kept", 16'h0400, q)
    brec <= 1'b1;
    cmpw();
    brec <= 1'b0;
    setw(16'h0400, 16'h3000);
    spc(1'b1, 11'h300, 6'h10);
    $display("done t_stat");
  endtask : t_stat
  task automatic t_nobat;
    bat <= 1'b0;
    cmpw();
    rd(csl_pkg::IDX_STATUS);
    `CHK("battery_pin bit", 1'b0, q[14])
    wr(csl_pkg::IDX_CURRENT, 16'h0400);
    rd(csl_pkg::IDX_CURRENT);
    `CHK("held reset", 16'h0000, q)
    spc(1'b1, 11'h480, 6'h02);
    bat <= 1'b1;
    cmpw();
    setw(16'h0400, 16'h3000);
    byteenable_i <= 4'hC;
    wr(csl_pkg::IDX_CURRENT, 16'h0800);
    byteenable_i <= 4'hF;
    rd(csl_pkg::IDX_CURRENT);
    `CHK("lanes", 16'h0400, q)
    $display("done t_nobat");
  endtask : t_nobat
  task automatic t_suv;
    setw(16'h0400, 16'h3000);
    suv <= 1'b1;
    cmpw();
    wr(csl_pkg::IDX_CURRENT, 16'h0800);
    spc(1'b0, 11'h000, 6'h00);
    `CHK("uv source", 1'b0, source_switch_drive_o)
    suv <= 1'b0;
    cmpw();
    rd(csl_pkg::IDX_CURRENT);
    `CHK("uv por", csl_pkg::CURRENT_RST, q)
    $display("done t_suv");
  endtask : t_suv
  task automatic t_wdt;
    setw(16'h0400, 16'h3000);
    repeat (150) @(posedge sys_clk_i);
    `CHK("wdt early", 1'b1, charge_en_o)
    repeat (100) @(posedge sys_clk_i);
    rd(csl_pkg::IDX_STATUS);
    `CHK("wdt bits", 2'b10, {q[2], q[0]})
    spc(1'b0, 11'h300, 6'h10);
    wr(csl_pkg::IDX_VOLTAGE, 16'h3000);
    rd(csl_pkg::IDX_STATUS);
    `CHK("wdt clear", 2'b01, {q[2], q[0]})
    $display("done t_wdt");
  endtask : t_wdt
  initial begin
    repeat (6) @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    cmpw();
    t_reset();
    t_volt();
    t_curr();
    t_stat();
    t_nobat();
    t_suv();
    t_wdt();
    results();
  end
endmodule : charger_setpoint_status_logic_test
